// ==== design/vic_ctrl.sv ====
// Vectored interrupt controller with control bits, pin select and entry sequencer.
`timescale 1ns/1ps
`default_nettype none
module vic_ctrl
  import vic_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  input  wire vic_bus_s    BUS_I,
  output logic             TEST_BIT_O,
  output logic             TEST_VALID_O,
  input  wire logic        RETI_I,
  input  wire logic        INSTR_DONE_I,
  input  wire logic        EXT0_PIN_I,
  input  wire logic        EXT1_PIN_I,
  input  wire logic        TMA_EVENT_I,
  input  wire logic        TMB_EVENT_I,
  input  wire logic        SER_EVENT_I,
  output logic             IRQ_TAKE_O,
  output logic             PUSH_O,
  output logic             JUMP_O,
  output logic [13:0]      VECTOR_O,
  output logic             SP_RESET_O,
  output logic [3:0]       PIN_FUNC_O,
  output logic             GIE_O
);
  // ****************************************
  // State
  // ****************************************
  logic [NUM_SRC-1:0] flag_r;
  logic [NUM_SRC-1:0] mask_r;
  logic               gie_r;
  logic [3:0]         pin_func_r;
  logic               ext0_pin_d_r;
  logic               ext1_pin_d_r;
  logic [13:0]        vector_r;
  logic               test_bit_r;
  logic               test_valid_r;
  logic               sp_reset_r;
  vic_state_e         state_r;
  logic [NUM_SRC-1:0] pend;
  logic [NUM_SRC-1:0] hw_set;
  logic [NUM_SRC-1:0] sw_clr;
  logic [NUM_SRC-1:0] sw_mset;
  logic [NUM_SRC-1:0] sw_mclr;
  logic               any_pend;
  logic [13:0]        enc_vec;
  logic               ext0_fall;
  logic               ext1_fall;

  // Maps a word and bit to one-hot flag and mask selects plus enable and stack-reset select bits.
  function automatic logic [NUM_SRC*2+1:0] decode_bit(input logic [9:0] a, input logic [1:0] b);
    logic [NUM_SRC-1:0] f;
    logic [NUM_SRC-1:0] m;
    logic               gie;
    logic               sp;
    f = '0;
    m = '0;
    gie = 1'b0;
    sp = 1'b0;
    unique case (a)
      ADDR_CTRL_WORD0: begin
        gie = (b == 2'(BIT_GIE));
        sp = (b == 2'(BIT_SPRST));
        f[0] = (b == 2'(BIT_EXT0_F));
        m[0] = (b == 2'(BIT_EXT0_M));
      end
      ADDR_CTRL_WORD1: begin
        f[1] = (b == 2'(BIT_EXT1_F));
        m[1] = (b == 2'(BIT_EXT1_M));
        f[2] = (b == 2'(BIT_TMA_F));
        m[2] = (b == 2'(BIT_TMA_M));
      end
      ADDR_CTRL_WORD2: begin
        f[3] = (b == 2'(BIT_LOW_F));
        m[3] = (b == 2'(BIT_LOW_M));
      end
      ADDR_CTRL_WORD3: begin
        f[4] = (b == 2'(BIT_LOW_F));
        m[4] = (b == 2'(BIT_LOW_M));
      end
      default: ;
    endcase
    return {sp, gie, m, f};
  endfunction : decode_bit

  // ****************************************
  // Decode of bit operations
  // ****************************************
  logic [NUM_SRC*2+1:0] dec;
  assign dec = decode_bit(BUS_I.addr, BUS_I.bit_sel);
  // Software may clear a flag but never set one.
  assign sw_clr  = (BUS_I.op == BOP_CLR) ? dec[NUM_SRC-1:0] : '0;
  assign sw_mset = (BUS_I.op == BOP_SET) ? dec[2*NUM_SRC-1:NUM_SRC] : '0;
  assign sw_mclr = (BUS_I.op == BOP_CLR) ? dec[2*NUM_SRC-1:NUM_SRC] : '0;

  // Falling edges on routed pins and peripheral pulses set the flags.
  assign ext0_fall = pin_func_r[BIT_EXT0_SEL] & ext0_pin_d_r & ~EXT0_PIN_I;
  assign ext1_fall = pin_func_r[BIT_EXT1_SEL] & ext1_pin_d_r & ~EXT1_PIN_I;
  assign hw_set = {SER_EVENT_I, TMB_EVENT_I, TMA_EVENT_I, ext1_fall, ext0_fall};
  assign pend = flag_r & ~mask_r;

  vic_prio_enc u_enc (
    .PEND_I (pend),
    .ANY_O  (any_pend),
    .VEC_O  (enc_vec)
  );

  // ****************************************
  // Pin edge history
  // ****************************************
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ext0_pin_d_r <= 1'b1;
      ext1_pin_d_r <= 1'b1;
    end else begin
      ext0_pin_d_r <= EXT0_PIN_I;
      ext1_pin_d_r <= EXT1_PIN_I;
    end
  end

  // Request flags: a hardware set wins over a software clear in the same cycle.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      flag_r <= FLAG_RST;
    end else begin
      flag_r <= (flag_r & ~sw_clr) | hw_set;
    end
  end

  // Masks follow set and clear bit operations.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      mask_r <= MASK_RST;
    end else begin
      mask_r <= (mask_r | sw_mset) & ~sw_mclr;
    end
  end

  // Pin function select is written as a whole word only.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      pin_func_r <= PIN_FUNC_RST;
    end else if (BUS_I.op == BOP_WRITE && BUS_I.addr == ADDR_PIN_FUNC) begin
      pin_func_r <= BUS_I.wdata;
    end
  end

  // Stack reset pulses when its bit is cleared.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      sp_reset_r <= 1'b0;
    end else begin
      sp_reset_r <= (BUS_I.op == BOP_CLR) & dec[2*NUM_SRC+1];
    end
  end

  // ****************************************
  // Bit test read path
  // ****************************************
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      test_bit_r   <= 1'b0;
      test_valid_r <= 1'b0;
    end else if (BUS_I.op == BOP_TEST) begin
      test_bit_r   <= |(dec[NUM_SRC-1:0] & flag_r) | |(dec[2*NUM_SRC-1:NUM_SRC] & mask_r)
                      | (dec[2*NUM_SRC] & gie_r);
      test_valid_r <= |dec[2*NUM_SRC:0];
    end else begin
      test_valid_r <= 1'b0;
    end
  end

  // ****************************************
  // Entry sequencer
  // ****************************************
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state_r  <= ST_IDLE;
      vector_r <= VEC_RESET;
    end else begin
      unique case (state_r)
        ST_IDLE: if (gie_r && any_pend) begin
          state_r  <= ST_CYC1;
          vector_r <= enc_vec;
        end
        ST_CYC1: if (INSTR_DONE_I) state_r <= ST_CYC2;
        ST_CYC2: state_r <= ST_CYC3;
        ST_CYC3: state_r <= ST_IDLE;
      endcase
    end
  end

  // Global enable: cleared in cycle two, set by return; bit ops also reach it.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      gie_r <= GIE_RST;
    end else if (state_r == ST_CYC2) begin
      gie_r <= 1'b0;
    end else if (RETI_I || (BUS_I.op == BOP_SET && dec[2*NUM_SRC])) begin
      gie_r <= 1'b1;
    end else if (BUS_I.op == BOP_CLR && dec[2*NUM_SRC]) begin
      gie_r <= 1'b0;
    end
  end

  assign IRQ_TAKE_O   = (state_r == ST_CYC1);
  assign PUSH_O       = (state_r == ST_CYC2) || (state_r == ST_CYC3);
  assign JUMP_O       = (state_r == ST_CYC3);
  assign VECTOR_O     = vector_r;
  assign SP_RESET_O   = sp_reset_r;
  assign PIN_FUNC_O   = pin_func_r;
  assign GIE_O        = gie_r;
  assign TEST_BIT_O   = test_bit_r;
  assign TEST_VALID_O = test_valid_r;

  // ****************************************
  // Assertions
  // ****************************************
  a_gie_cleared_entry: assert property (@(posedge CLK_I) disable iff (RST_I)
    state_r == ST_CYC2 |=> !gie_r) else $error("Enable not cleared on entry.");
  a_entry_push_jump: assert property (@(posedge CLK_I) disable iff (RST_I)
    $rose(IRQ_TAKE_O) && INSTR_DONE_I |=> PUSH_O ##1 (PUSH_O && JUMP_O) ##1 !PUSH_O)
    else $error("Entry sequence wrong.");
  a_take_needs_gie: assert property (@(posedge CLK_I) disable iff (RST_I)
    $rose(IRQ_TAKE_O) |-> $past(gie_r) && $past(any_pend)) else $error("Taken while disabled.");
  a_no_sw_flag_set: assert property (@(posedge CLK_I) disable iff (RST_I)
    hw_set == '0 |=> (flag_r & ~$past(flag_r)) == '0) else $error("Flag set without event.");
  a_ext0_vector: assert property (@(posedge CLK_I) disable iff (RST_I)
    state_r == ST_IDLE && gie_r && pend[0] |=> vector_r == VEC_EXT0) else $error("Wrong top vector.");
  a_serial_vector: assert property (@(posedge CLK_I) disable iff (RST_I)
    state_r == ST_IDLE && gie_r && pend == 5'h10 |=> vector_r == VEC_SERIAL) else $error("Bad serial vector.");
  a_ext0_edge_sets: assert property (@(posedge CLK_I) disable iff (RST_I)
    ext0_fall |=> flag_r[0]) else $error("Edge lost.");
  a_ext_pin_gated: assert property (@(posedge CLK_I) disable iff (RST_I)
    !pin_func_r[BIT_EXT1_SEL] && !TMB_EVENT_I && !flag_r[1] |=> !flag_r[1]) else $error("Unrouted pin set flag.");
  // Checked on the cycle after a reset edge, so the unset state before the first edge is never judged.
  a_reset_masks: assert property (@(posedge CLK_I) RST_I |=> mask_r == MASK_RST && flag_r == FLAG_RST
    && gie_r == GIE_RST && pin_func_r == PIN_FUNC_RST) else $error("Reset values wrong.");
  c_entry_done: cover property (@(posedge CLK_I) disable iff (RST_I) JUMP_O);
  c_reti: cover property (@(posedge CLK_I) disable iff (RST_I) RETI_I && !gie_r);
  c_two_pending: cover property (@(posedge CLK_I) disable iff (RST_I) pend[0] && pend[4] && gie_r);
endmodule : vic_ctrl
`default_nettype wire

// ==== design/vic_pkg.sv ====
// Package of constants and types for the vectored interrupt controller.
package vic_pkg;
  // ****************************************
  // Address map and field layout
  // ****************************************
  localparam logic [9:0] ADDR_CTRL_WORD0 = 10'h000;
  localparam logic [9:0] ADDR_CTRL_WORD1 = 10'h001;
  localparam logic [9:0] ADDR_CTRL_WORD2 = 10'h002;
  localparam logic [9:0] ADDR_CTRL_WORD3 = 10'h003;
  localparam logic [9:0] ADDR_PIN_FUNC   = 10'h004;
  // Control word 0 fields.
  localparam int BIT_GIE    = 0;
  localparam int BIT_SPRST  = 1;
  localparam int BIT_EXT0_F = 2;
  localparam int BIT_EXT0_M = 3;
  // Control word 1 fields.
  localparam int BIT_EXT1_F = 0;
  localparam int BIT_EXT1_M = 1;
  localparam int BIT_TMA_F  = 2;
  localparam int BIT_TMA_M  = 3;
  // Control words 2 and 3 fields.
  localparam int BIT_LOW_F  = 0;
  localparam int BIT_LOW_M  = 1;
  // Pin function select fields.
  localparam int BIT_SO_SEL   = 0;
  localparam int BIT_SI_SEL   = 1;
  localparam int BIT_EXT0_SEL = 2;
  localparam int BIT_EXT1_SEL = 3;
  // ****************************************
  // Reset values and vectors
  // ****************************************
  localparam int          NUM_SRC         = 5;
  localparam logic [4:0]  FLAG_RST        = 5'h00;
  localparam logic [4:0]  MASK_RST        = 5'h1f;
  localparam logic        GIE_RST         = 1'h0;
  localparam logic [3:0]  PIN_FUNC_RST    = 4'h0;
  localparam logic [13:0] VEC_RESET       = 14'h0000;
  localparam logic [13:0] VEC_EXT0        = 14'h0002;
  localparam logic [13:0] VEC_EXT1        = 14'h0004;
  localparam logic [13:0] VEC_TMA         = 14'h0006;
  localparam logic [13:0] VEC_TMB         = 14'h0008;
  localparam logic [13:0] VEC_SERIAL      = 14'h000c;
  localparam int          ENTRY_CYCLES    = 3;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    BOP_NONE, BOP_SET, BOP_CLR, BOP_TEST, BOP_WRITE
  } vic_bop_e;
  typedef struct packed {
    vic_bop_e   op;
    logic [9:0] addr;
    logic [1:0] bit_sel;
    logic [3:0] wdata;
  } vic_bus_s;
  typedef enum logic [1:0] {ST_IDLE, ST_CYC1, ST_CYC2, ST_CYC3} vic_state_e;
endpackage : vic_pkg

// ==== design/vic_prio_enc.sv ====
// Fixed priority encoder that turns pending requests into a vector.
`timescale 1ns/1ps
`default_nettype none
module vic_prio_enc
  import vic_pkg::*;
(
  input  wire logic [NUM_SRC-1:0] PEND_I,
  output logic                    ANY_O,
  output logic [13:0]             VEC_O
);
  // ****************************************
  // Priority selection
  // ****************************************
  // Lowest index wins, so a later source is only chosen when all earlier are idle.
  always_comb begin
    ANY_O = |PEND_I;
    VEC_O = VEC_RESET;
    if (PEND_I[0]) begin
      VEC_O = VEC_EXT0;
    end else if (PEND_I[1]) begin
      VEC_O = VEC_EXT1;
    end else if (PEND_I[2]) begin
      VEC_O = VEC_TMA;
    end else if (PEND_I[3]) begin
      VEC_O = VEC_TMB;
    end else if (PEND_I[4]) begin
      VEC_O = VEC_SERIAL;
    end
  end
endmodule : vic_prio_enc
`default_nettype wire

// ==== testbench/vic_src_model.sv ====
// Model of the request pins and peripheral event sources around the controller.
`timescale 1ns/1ps
`default_nettype none
module vic_src_model
  import vic_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic [NUM_SRC-1:0] fire_i,
  output logic                    ext0_o,
  output logic                    ext1_o,
  output logic [2:0]              evt_o
);
  logic [1:0] low0_r = 2'h0;
  logic [1:0] low1_r = 2'h0;
  logic [2:0] evt_r  = 3'h0;
  // ****************************************
  // Request pins
  // ****************************************
  // Pins rest high like pulled-up lines and drop low for two cycles per request.
  always_ff @(posedge clk_i) begin
    low0_r <= fire_i[0] ? 2'h3 : {1'b0, low0_r[1]};
    low1_r <= fire_i[1] ? 2'h3 : {1'b0, low1_r[1]};
  end
  assign ext0_o = ~|low0_r;
  assign ext1_o = ~|low1_r;
  // Timer and serial events are single-cycle pulses.
  always_ff @(posedge clk_i) begin
    evt_r <= fire_i[4:2];
  end
  assign evt_o = evt_r;
endmodule : vic_src_model
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking testbench for the vectored interrupt controller.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import vic_pkg::*;
();
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         reti = 1'b0;
  logic         done = 1'b0;
  vic_bus_s     bus = '0;
  logic [4:0]   fire = 5'h00;
  logic         ext0, ext1, tbit, tval, take, push, jump, spr, gie;
  logic [2:0]   evt;
  logic [13:0]  vec;
  logic [3:0]   pf;
  logic [19:0]  lf = 20'h119ac;
  logic [1:0]   tq [$];
  logic [13:0]  vq [$];
  logic         seen_t = 1'b0;
  logic         take_d = 1'b0;
  int           err_count = 0;
  int           checks = 0;
  logic [9:0]   fa [5] = '{ADDR_CTRL_WORD0, ADDR_CTRL_WORD1, ADDR_CTRL_WORD1, ADDR_CTRL_WORD2, ADDR_CTRL_WORD3};
  logic [1:0]   fb [5] = '{2'h2, 2'h0, 2'h2, 2'h0, 2'h0};
  logic [13:0]  vecs [5] = '{VEC_EXT0, VEC_EXT1, VEC_TMA, VEC_TMB, VEC_SERIAL};
  vic_ctrl dut_u (.CLK_I(clk), .RST_I(rst), .BUS_I(bus), .TEST_BIT_O(tbit), .TEST_VALID_O(tval),
    .RETI_I(reti), .INSTR_DONE_I(done), .EXT0_PIN_I(ext0), .EXT1_PIN_I(ext1), .TMA_EVENT_I(evt[0]),
    .TMB_EVENT_I(evt[1]), .SER_EVENT_I(evt[2]), .IRQ_TAKE_O(take), .PUSH_O(push), .JUMP_O(jump),
    .VECTOR_O(vec), .SP_RESET_O(spr), .PIN_FUNC_O(pf), .GIE_O(gie));
  vic_src_model src_u (.clk_i(clk), .fire_i(fire), .ext0_o(ext0), .ext1_o(ext1), .evt_o(evt));
  // ****************************************
  // Clock, random source and helpers
  // ****************************************
  // Clock of 20 ns period.
  always #10 clk = ~clk;
  function automatic logic [19:0] lfsr(input logic [19:0] x);
    return {x[18:0], x[19] ^ x[16]};
  endfunction : lfsr
  // The instruction-done level follows the random stream so entry stalls vary.
  always @(posedge clk) begin
    lf <= lfsr(lf);
    done <= lf[0];
  end
  task automatic chk(input logic [13:0] seen, input logic [13:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic bop(input vic_bop_e op, input logic [9:0] a, input logic [1:0] b, input logic [3:0] w);
    @(posedge clk);
    bus <= '{op, a, b, w};
    @(posedge clk);
    bus <= '0;
  endtask : bop
  task automatic tst(input logic [9:0] a, input logic [1:0] b, input logic v, input logic e);
    tq.push_back({v, e});
    bop(BOP_TEST, a, b, 4'h0);
  endtask : tst
  task automatic fire_src(input logic [4:0] f);
    @(posedge clk);
    fire <= f;
    @(posedge clk);
    fire <= 5'h00;
    repeat (4) @(posedge clk);
  endtask : fire_src
  task automatic quiet;
    repeat (8) begin
      @(posedge clk);
      chk(take, 1'b0);
    end
  endtask : quiet
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run
  // Monitor takes the oldest note whenever a test answer or an entry appears.
  always @(posedge clk) begin
    if (seen_t) begin
      chk(tval, tq[0][1]);
      if (tq[0][1]) chk(tbit, tq[0][0]);
      void'(tq.pop_front());
    end
    seen_t = (bus.op == BOP_TEST);
    if (take === 1'b1 && !take_d) chk(vec, vq.pop_front());
    take_d = (take === 1'b1);
    if (jump === 1'b1) chk(push, 1'b1);
  end
  // Watchdog cuts a hang short.
  initial begin
    #400000;
    err_count++;
    complete_run();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [3:0] w;
    int n;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      tst(fa[i], fb[i], 1'b1, 1'b0);
      tst(fa[i], fb[i] + 2'h1, 1'b1, 1'b1);
    end
    tst(ADDR_CTRL_WORD0, 2'h0, 1'b1, 1'b0);
    tst(ADDR_CTRL_WORD2, 2'h3, 1'b0, 1'b0);
    tst(ADDR_CTRL_WORD3, 2'h2, 1'b0, 1'b0);
    chk(pf, PIN_FUNC_RST);
    chk(vec, VEC_RESET);
    $display("test reset values done");
    for (int i = 0; i < 5; i++) bop(BOP_SET, fa[i], fb[i], 4'h0);
    fire_src(5'h1f);
    for (int i = 0; i < 5; i++) tst(fa[i], fb[i], 1'b1, i > 1);
    w = {2'h3, lf[1:0]};
    bop(BOP_WRITE, ADDR_PIN_FUNC, 2'h0, w);
    @(posedge clk);
    chk(pf, w);
    fire_src(5'h03);
    tst(ADDR_CTRL_WORD0, 2'(BIT_EXT0_F), 1'b1, 1'b1);
    tst(ADDR_CTRL_WORD1, 2'(BIT_EXT1_F), 1'b1, 1'b1);
    $display("test flags and pin select done");
    bop(BOP_SET, ADDR_CTRL_WORD0, 2'(BIT_GIE), 4'h0);
    quiet();
    bop(BOP_CLR, ADDR_CTRL_WORD0, 2'(BIT_GIE), 4'h0);
    for (int i = 0; i < 5; i++) bop(BOP_CLR, fa[i], fb[i] + 2'h1, 4'h0);
    quiet();
    vq.push_back(vecs[0]);
    bop(BOP_SET, ADDR_CTRL_WORD0, 2'(BIT_GIE), 4'h0);
    for (int i = 0; i < 5; i++) begin
      n = 0;
      while (jump !== 1'b1 && n < 50) begin
        @(posedge clk);
        n++;
      end
      chk(n < 50, 1'b1);
      tst(ADDR_CTRL_WORD0, 2'(BIT_GIE), 1'b1, 1'b0);
      tst(fa[i], fb[i], 1'b1, 1'b1);
      bop(BOP_CLR, fa[i], fb[i], 4'h0);
      if (i < 4) vq.push_back(vecs[i + 1]);
      @(posedge clk);
      reti <= 1'b1;
      @(posedge clk);
      reti <= 1'b0;
    end
    repeat (2) @(posedge clk);
    chk(gie, 1'b1);
    // Request 1 pin used as timer B clock: software masks it, so its edges set the flag but never enter.
    bop(BOP_SET, ADDR_CTRL_WORD1, 2'(BIT_EXT1_M), 4'h0);
    fire_src(5'h02);
    quiet();
    chk(gie, 1'b1);
    tst(ADDR_CTRL_WORD1, 2'(BIT_EXT1_F), 1'b1, 1'b1);
    bop(BOP_CLR, ADDR_CTRL_WORD1, 2'(BIT_EXT1_F), 4'h0);
    $display("test priority entry done");
    bop(BOP_CLR, ADDR_CTRL_WORD0, 2'(BIT_SPRST), 4'h0);
    n = 0;
    repeat (3) begin
      @(posedge clk);
      if (spr === 1'b1) n++;
    end
    chk(14'(n), 14'h0001);
    $display("test stack reset done");
    complete_run();
  end
endmodule : testbench
`default_nettype wire
